// ### common/ppaps_pkg.sv
package ppaps_pkg;
  localparam int          AW          = 8;
  localparam int          DW          = 16;
  localparam int          NBUF        = 4;
  localparam int          NPAD        = 11;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_ADDR    = 8'h00;
  localparam logic [7:0]  OFS_EN      = 8'h04;
  localparam logic [7:0]  OFS_STAT    = 8'h08;
  localparam logic [7:0]  OFS_IBUF0   = 8'h10;
  localparam logic [7:0]  OFS_OBUF0   = 8'h20;
  localparam logic [7:0]  OFS_STEP    = 8'h04;
  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int          B_CS        = 14;
  localparam int          B_IBF       = 15;
  localparam int          B_INPUT_OVERFLOW_FLAG      = 14;
  localparam int          B_IBXF      = 8;
  localparam int          B_OBE       = 7;
  localparam int          B_OUTPUT_UNDERFLOW_FLAG      = 6;
  localparam int          B_OBXE      = 0;
  localparam int          LOW_PADS    = 2;
  localparam logic [15:0] MASK_FULL   = 16'h47FF;
  localparam logic [15:0] MASK_SMALL  = 16'h4003;
  localparam logic [15:0] RST_REG     = 16'h0000;
  localparam logic [3:0]  RST_IBF     = 4'h0;
  localparam logic [3:0]  RST_OBE     = 4'hF;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
endpackage : ppaps_pkg

// ### design/ppaps_top.sv
`timescale 1ns/1ps
module ppaps_top
  import ppaps_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic [ppaps_pkg::AW-1:0] REG_ADDR,
  input  wire logic [ppaps_pkg::DW-1:0] REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [ppaps_pkg::DW-1:0] REG_RDATA,
  input  wire logic                    ALE_MODE,
  input  wire logic                    ALE_HIGH,
  input  wire logic                    ALE_LOW,
  input  wire logic                    EXT_WR,
  input  wire logic                    EXT_RD,
  input  wire logic [1:0]              EXT_IDX,
  input  wire logic [7:0]              EXT_WDATA,
  output logic      [7:0]              EXT_RDATA,
  input  wire logic                    GPIO_CS_O,
  input  wire logic                    GPIO_CS_OE_N,
  input  wire logic [ppaps_pkg::NPAD-1:0] GPIO_A_O,
  input  wire logic [ppaps_pkg::NPAD-1:0] GPIO_A_OE_N,
  output logic                         PAD_CS_O,
  output logic                         PAD_CS_OE_N,
  output logic      [ppaps_pkg::NPAD-1:0] PAD_A_O,
  output logic      [ppaps_pkg::NPAD-1:0] PAD_A_OE_N
);
  import ppaps_pkg::*;

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  logic [15:0] impl_mask;
  logic        wr_addr;
  logic        wr_en;
  logic        wr_stat;
  logic        hit_ib;
  logic        hit_ob;
  logic [1:0]  bus_idx;
  logic [7:0]  ib_base;
  logic [7:0]  ob_base;

  assign impl_mask = SMALL_PKG ? MASK_SMALL : MASK_FULL;
  assign wr_addr   = REG_WR && (REG_ADDR == OFS_ADDR);
  assign wr_en     = REG_WR && (REG_ADDR == OFS_EN);
  assign wr_stat   = REG_WR && (REG_ADDR == OFS_STAT);
  assign ib_base   = REG_ADDR - OFS_IBUF0;
  assign ob_base   = REG_ADDR - OFS_OBUF0;
  assign hit_ib    = (REG_ADDR >= OFS_IBUF0) && (ib_base < (OFS_STEP * 8'(NBUF)))
                     && (REG_ADDR[1:0] == 2'b00);
  assign hit_ob    = (REG_ADDR >= OFS_OBUF0) && (ob_base < (OFS_STEP * 8'(NBUF)))
                     && (REG_ADDR[1:0] == 2'b00);
  assign bus_idx   = hit_ib ? ib_base[3:2] : ob_base[3:2];

  // ---------------------------------------------------------------
  // Address and pad enable registers
  // ---------------------------------------------------------------
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [15:0] en_q;
  logic [15:0] en_d;

  // Masking at write time keeps absent bits at zero for good.
  assign addr_d = wr_addr ? (REG_WDATA & impl_mask) : addr_q;
  assign en_d   = wr_en ? (REG_WDATA & impl_mask) : en_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q <= RST_REG;
      en_q   <= RST_REG;
    end else begin
      addr_q <= addr_d;
      en_q   <= en_d;
    end
  end

  // ---------------------------------------------------------------
  // Parallel bus strobes: pins are synchronised before use
  // ---------------------------------------------------------------
  logic [11:0] ext_s1_q;
  logic [11:0] ext_s2_q;
  logic [1:0]  ext_s3_q;
  logic        ext_wr_p;
  logic        ext_rd_p;
  logic [1:0]  ext_idx_s;
  logic [7:0]  ext_dat_s;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_s1_q <= 12'h000;
      ext_s2_q <= 12'h000;
      ext_s3_q <= 2'b00;
    end else begin
      ext_s1_q <= {EXT_WR, EXT_RD, EXT_IDX, EXT_WDATA};
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q[11:10];
    end
  end

  assign ext_wr_p  = ext_s2_q[11] && !ext_s3_q[1];
  assign ext_rd_p  = ext_s2_q[10] && !ext_s3_q[0];
  assign ext_idx_s = ext_s2_q[9:8];
  assign ext_dat_s = ext_s2_q[7:0];

  // ---------------------------------------------------------------
  // Byte buffers and their flags
  // ---------------------------------------------------------------
  logic [7:0] ibuf_q [NBUF];
  logic [7:0] output_underflow_flag_q [NBUF];
  logic [3:0] ibf_q;
  logic [3:0] ibf_d;
  logic [3:0] obe_q;
  logic [3:0] obe_d;
  logic       input_overflow_flag_q;
  logic       input_overflow_flag_d;
  logic       output_underflow_flag_flag_q;
  logic       output_underflow_flag_flag_d;
  logic       ovf_ev;
  logic       ufl_ev;
  logic [7:0] ext_rdata_q;
  logic [7:0] ext_rdata_d;

  assign ovf_ev = ext_wr_p && ibf_q[ext_idx_s];
  assign ufl_ev = ext_rd_p && obe_q[ext_idx_s];

  genvar g;
  generate
    for (g = 0; g < NBUF; g++) begin : g_buf
      logic ib_set;
      logic ib_clr;
      logic ob_fill;
      logic ob_drain;
      assign ib_set   = ext_wr_p && (ext_idx_s == 2'(g)) && !ibf_q[g];
      assign ib_clr   = REG_RD && hit_ib && (bus_idx == 2'(g));
      assign ob_fill  = REG_WR && hit_ob && (bus_idx == 2'(g));
      assign ob_drain = ext_rd_p && (ext_idx_s == 2'(g)) && !obe_q[g];
      // A byte arriving while the flag is set is dropped; a read in that cycle still clears the flag.
      assign ibf_d[g] = ib_set | (ibf_q[g] & !ib_clr);
      assign obe_d[g] = ob_drain | (obe_q[g] & !ob_fill);

      always_ff @(posedge CLK) begin
        if (RST) begin
          ibuf_q[g] <= RST_BYTE;
          output_underflow_flag_q[g] <= RST_BYTE;
        end else begin
          if (ib_set) begin
            ibuf_q[g] <= ext_dat_s;
          end
          if (ob_fill) begin
            output_underflow_flag_q[g] <= REG_WDATA[7:0];
          end
        end
      end
    end
  endgenerate

  // Writing zero clears a sticky flag; a hardware event in that cycle wins.
  assign input_overflow_flag_d      = ovf_ev | (input_overflow_flag_q & !(wr_stat && !REG_WDATA[B_INPUT_OVERFLOW_FLAG]));
  assign output_underflow_flag_flag_d = ufl_ev | (output_underflow_flag_flag_q & !(wr_stat && !REG_WDATA[B_OUTPUT_UNDERFLOW_FLAG]));
  assign ext_rdata_d = ext_rd_p ? output_underflow_flag_q[ext_idx_s] : ext_rdata_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ibf_q       <= RST_IBF;
      obe_q       <= RST_OBE;
      input_overflow_flag_q      <= 1'b0;
      output_underflow_flag_flag_q <= 1'b0;
      ext_rdata_q <= RST_BYTE;
    end else begin
      ibf_q       <= ibf_d;
      obe_q       <= obe_d;
      input_overflow_flag_q      <= input_overflow_flag_d;
      output_underflow_flag_flag_q <= output_underflow_flag_flag_d;
      ext_rdata_q <= ext_rdata_d;
    end
  end

  assign EXT_RDATA = ext_rdata_q;

  // ---------------------------------------------------------------
  // Status word and read-back
  // ---------------------------------------------------------------
  logic [15:0] stat_w;
  logic [15:0] rd_mux;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb begin
    stat_w = RST_REG;
    stat_w[B_IBF]           = &ibf_q;
    stat_w[B_INPUT_OVERFLOW_FLAG]          = input_overflow_flag_q;
    stat_w[B_IBXF +: NBUF]  = ibf_q;
    stat_w[B_OBE]           = &obe_q;
    stat_w[B_OUTPUT_UNDERFLOW_FLAG]          = output_underflow_flag_flag_q;
    stat_w[B_OBXE +: NBUF]  = obe_q;
  end

  assign rd_mux  = (REG_ADDR == OFS_ADDR) ? addr_q :
                   (REG_ADDR == OFS_EN)   ? en_q :
                   (REG_ADDR == OFS_STAT) ? stat_w :
                   hit_ib ? {8'h00, ibuf_q[bus_idx]} :
                   hit_ob ? {8'h00, output_underflow_flag_q[bus_idx]} : RST_REG;
  assign rdata_d = REG_RD ? rd_mux : RST_REG;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= RST_REG;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // ---------------------------------------------------------------
  // Pad routing
  // ---------------------------------------------------------------
  // Chip select is shown active high; polarity selection lives elsewhere.
  assign PAD_CS_O    = en_q[B_CS] ? addr_q[B_CS] : GPIO_CS_O;
  assign PAD_CS_OE_N = en_q[B_CS] ? 1'b0 : GPIO_CS_OE_N;

  generate
    for (g = 0; g < NPAD; g++) begin : g_pad
      logic port_val;
      if (g < LOW_PADS) begin : g_low
        assign port_val = ALE_MODE ? ((g == 1) ? ALE_HIGH : ALE_LOW) : addr_q[g];
      end else begin : g_high
        assign port_val = addr_q[g];
      end
      if (SMALL_PKG && (g >= LOW_PADS)) begin : g_absent
        assign PAD_A_O[g]    = 1'b0;
        assign PAD_A_OE_N[g] = 1'b1;
      end else begin : g_present
        assign PAD_A_O[g]    = en_q[g] ? port_val : GPIO_A_O[g];
        assign PAD_A_OE_N[g] = en_q[g] ? 1'b0 : GPIO_A_OE_N[g];
      end
    end
  endgenerate

endmodule : ppaps_top

// ### dv/ppaps_ext_model.sv
`timescale 1ns/1ps
module ppaps_ext_model (
  input  logic       CLK,
  output logic       EXT_WR,
  output logic       EXT_RD,
  output logic [1:0] EXT_IDX,
  output logic [7:0] EXT_WDATA
);
  initial begin
    EXT_WR = 1'b0;
    EXT_RD = 1'b0;
    EXT_IDX = 2'h0;
    EXT_WDATA = 8'h00;
  end
  // Index and data settle two cycles early and stay three late so the synchroniser sees them.
  task automatic xfer(input logic w, input logic [1:0] i, input logic [7:0] b);
    EXT_IDX <= i;
    EXT_WDATA <= b;
    repeat (2) @(posedge CLK);
    if (w) EXT_WR <= 1'b1;
    else EXT_RD <= 1'b1;
    repeat (3) @(posedge CLK);
    EXT_WR <= 1'b0;
    EXT_RD <= 1'b0;
    repeat (3) @(posedge CLK);
    EXT_IDX <= ~i;
    EXT_WDATA <= ~b;
    // One more edge keeps a back-to-back call from driving the index twice in one step.
    @(posedge CLK);
  endtask : xfer
endmodule : ppaps_ext_model

// ### dv/ppaps_monitor.sv
`timescale 1ns/1ps
module ppaps_monitor
  import ppaps_pkg::*;
#(parameter bit SMALL_PKG = 1'b0) (
  input logic                         CLK,
  input logic                         RST,
  input logic [ppaps_pkg::AW-1:0]     REG_ADDR,
  input logic [ppaps_pkg::DW-1:0]     REG_WDATA,
  input logic                         REG_WR,
  input logic                         REG_RD,
  input logic [ppaps_pkg::DW-1:0]     REG_RDATA,
  input logic                         ALE_MODE,
  input logic                         ALE_HIGH,
  input logic                         ALE_LOW,
  input logic                         GPIO_CS_O,
  input logic                         GPIO_CS_OE_N,
  input logic [ppaps_pkg::NPAD-1:0]   GPIO_A_O,
  input logic [ppaps_pkg::NPAD-1:0]   GPIO_A_OE_N,
  input logic                         PAD_CS_O,
  input logic                         PAD_CS_OE_N,
  input logic [ppaps_pkg::NPAD-1:0]   PAD_A_O,
  input logic [ppaps_pkg::NPAD-1:0]   PAD_A_OE_N
);
  logic [15:0] addr_q, en_q, msk;
  logic [10:0] src, ep, eoe;
  // Shadow copies of the pin registers let every pad be checked after any write order.
  assign msk = SMALL_PKG ? MASK_SMALL : MASK_FULL;
  assign src = {addr_q[10:2], ALE_MODE ? {ALE_HIGH, ALE_LOW} : addr_q[1:0]};
  assign ep  = (en_q[10:0] & src) | (~en_q[10:0] & GPIO_A_O);
  assign eoe = ~en_q[10:0] & GPIO_A_OE_N;
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q <= RST_REG;
      en_q   <= RST_REG;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_ADDR) addr_q <= REG_WDATA & msk;
      if (REG_ADDR == OFS_EN) en_q <= REG_WDATA & msk;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  AST_CS_PAD: assert property (PAD_CS_O == (en_q[B_CS] ? addr_q[B_CS] : GPIO_CS_O))
    else $error("cs pad level");
  AST_CS_OE: assert property (PAD_CS_OE_N == (en_q[B_CS] ? 1'b0 : GPIO_CS_OE_N))
    else $error("cs pad enable");
  AST_A_HI: assert property (!SMALL_PKG |-> PAD_A_O[10:2] == ep[10:2]
    && PAD_A_OE_N[10:2] == eoe[10:2]) else $error("upper address pads");
  AST_A_LO: assert property (PAD_A_O[1:0] == ep[1:0] && PAD_A_OE_N[1:0] == eoe[1:0])
    else $error("low address pads");
  AST_SMALL: assert property (SMALL_PKG |-> PAD_A_O[10:2] == 9'h000
    && PAD_A_OE_N[10:2] == 9'h1FF) else $error("absent pads driven");
  AST_ADDR_RB: assert property ($past(REG_RD) && $past(REG_ADDR) == OFS_ADDR
    |-> REG_RDATA == $past(addr_q)) else $error("address readback");
  AST_EN_RB: assert property ($past(REG_RD) && $past(REG_ADDR) == OFS_EN
    |-> REG_RDATA == $past(en_q)) else $error("enable readback");
  AST_STAT: assert property ($past(REG_RD) && $past(REG_ADDR) == OFS_STAT |->
    REG_RDATA[13:12] == 2'h0 && REG_RDATA[5:4] == 2'h0 && REG_RDATA[15] == &REG_RDATA[11:8])
    else $error("status layout");
  cover property (!PAD_CS_OE_N && PAD_CS_O);
  cover property ($past(REG_RD) && REG_RDATA[B_INPUT_OVERFLOW_FLAG]);
  cover property ($past(REG_RD) && REG_RDATA[B_OUTPUT_UNDERFLOW_FLAG]);
endmodule : ppaps_monitor

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ppaps_pkg::*;
  logic        CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, rd_d = 1'b0;
  logic        ALE_MODE = 1'b0, ALE_HIGH = 1'b0, ALE_LOW = 1'b0;
  logic        GPIO_CS_O = 1'b0, GPIO_CS_OE_N = 1'b1, PAD_CS_O, PAD_CS_OE_N, EXT_WR, EXT_RD;
  logic [7:0]  REG_ADDR = 8'h00, EXT_RDATA, EXT_WDATA, b;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, st;
  logic [10:0] GPIO_A_O = 11'h000, GPIO_A_OE_N = 11'h7FF, PAD_A_O, PAD_A_OE_N;
  logic [1:0]  EXT_IDX;
  logic [15:0] expq[$];
  logic [15:0] expq_s[$];
  logic [15:0] REG_RDATA_S;
  logic        PAD_CS_O_S, PAD_CS_OE_N_S;
  logic [10:0] PAD_A_O_S, PAD_A_OE_N_S;
  int          fails = 0, cmp_count = 0;
  initial forever #2 CLK = ~CLK;
  ppaps_top i_ppaps_top (.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .ALE_MODE, .ALE_HIGH, .ALE_LOW, .EXT_WR, .EXT_RD, .EXT_IDX, .EXT_WDATA, .EXT_RDATA,
    .GPIO_CS_O, .GPIO_CS_OE_N, .GPIO_A_O, .GPIO_A_OE_N, .PAD_CS_O, .PAD_CS_OE_N,
    .PAD_A_O, .PAD_A_OE_N);
  // A second copy in the small package lets the absent-pad logic be exercised too.
  ppaps_top #(.SMALL_PKG(1'b1)) i_ppaps_top_small (.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA(REG_RDATA_S), .ALE_MODE, .ALE_HIGH, .ALE_LOW, .EXT_WR, .EXT_RD,
    .EXT_IDX, .EXT_WDATA, .EXT_RDATA(), .GPIO_CS_O, .GPIO_CS_OE_N, .GPIO_A_O, .GPIO_A_OE_N,
    .PAD_CS_O(PAD_CS_O_S), .PAD_CS_OE_N(PAD_CS_OE_N_S), .PAD_A_O(PAD_A_O_S),
    .PAD_A_OE_N(PAD_A_OE_N_S));
  ppaps_ext_model i_ppaps_ext_model (.CLK, .EXT_WR, .EXT_RD, .EXT_IDX, .EXT_WDATA);
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    expq_s.push_back(((a == OFS_ADDR) || (a == OFS_EN)) ? (e & MASK_SMALL) : e);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask : rd
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Read data stand for one cycle only, so they are taken mid-cycle after the strobe.
  always @(posedge CLK) rd_d <= REG_RD;
  always @(negedge CLK) begin
    if (rd_d) begin
      check("read data", REG_RDATA, expq.pop_front());
      check("small read data", REG_RDATA_S, expq_s.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    results();
  end
  initial begin
    void'($urandom(32'hF85A_0FF1));
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(OFS_ADDR, RST_REG);
    rd(OFS_STAT, 16'h008F);
    rd(8'hFC, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      {ALE_MODE, ALE_HIGH, ALE_LOW, GPIO_CS_O, GPIO_CS_OE_N, GPIO_A_O, GPIO_A_OE_N}
        <= 27'($urandom);
      st = 16'($urandom);
      wr(OFS_ADDR, st);
      rd(OFS_ADDR, st & MASK_FULL);
      st = 16'($urandom);
      wr(OFS_EN, st);
      rd(OFS_EN, st & MASK_FULL);
      wr(OFS_STAT, 16'hFFFF);
      rd(OFS_STAT, 16'h008F);
    end
    wr(OFS_ADDR, 16'h4000);
    wr(OFS_EN, 16'h4003);
    $display("test pins done");
    for (int k = 0; k < 4; k++) i_ppaps_ext_model.xfer(1'b1, 2'(k), 8'(8'hA0 + k));
    rd(OFS_STAT, 16'h8F8F);
    i_ppaps_ext_model.xfer(1'b1, 2'h0, 8'h5A);
    rd(OFS_STAT, 16'hCF8F);
    rd(OFS_IBUF0, 16'h00A0);
    rd(OFS_STAT, 16'h4E8F);
    wr(OFS_STAT, 16'h0000);
    rd(OFS_STAT, 16'h0E8F);
    $display("test input done");
    i_ppaps_ext_model.xfer(1'b0, 2'h2, 8'h00);
    rd(OFS_STAT, 16'h0ECF);
    wr(OFS_STAT, 16'h0000);
    rd(OFS_STAT, 16'h0E8F);
    b = 8'($urandom);
    wr(OFS_OBUF0, {8'h00, b});
    rd(OFS_STAT, 16'h0E0E);
    rd(OFS_OBUF0, {8'h00, b});
    i_ppaps_ext_model.xfer(1'b0, 2'h0, 8'h00);
    check("ext byte", {8'h00, EXT_RDATA}, {8'h00, b});
    $display("test output done");
    results();
  end
endmodule : testbench
bind ppaps_top ppaps_monitor #(.SMALL_PKG(SMALL_PKG)) i_ppaps_monitor (.CLK, .RST, .REG_ADDR,
  .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .ALE_MODE, .ALE_HIGH, .ALE_LOW, .GPIO_CS_O,
  .GPIO_CS_OE_N, .GPIO_A_O, .GPIO_A_OE_N, .PAD_CS_O, .PAD_CS_OE_N, .PAD_A_O, .PAD_A_OE_N);
